// ---- hbac_defines.svh ----
`ifndef HBAC_DEFINES_SVH
`define HBAC_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define HBAC_IDX_W 7
`define HBAC_IDX_COMMAND 7'h00
`define HBAC_IDX_HOST_BUS 7'h01
`define HBAC_IDX_BUF_SET 7'h02
`define HBAC_IDX_VERSION 7'h7f

// ----------------------------------------
// command_control fields
// ----------------------------------------
`define HBAC_CMD_PWRDN_BIT 7
`define HBAC_CMD_RADIO_OFF_BIT 6
`define HBAC_CMD_CODE_MSB 4
`define HBAC_CMD_CODE_LSB 0
`define HBAC_CMD_CODE_IDLE 5'h00
`define HBAC_CMD_RESET 8'h00

// ----------------------------------------
// host_bus_access fields
// ----------------------------------------
`define HBAC_HB_UNLOCK_BIT 7
`define HBAC_HB_OWN_HOST_BIT 6
`define HBAC_HB_OWN_SM_BIT 5
`define HBAC_HB_IF_MSB 3
`define HBAC_HB_IF_LSB 2
`define HBAC_HB_RESET 8'h00

// ----------------------------------------
// buffer_settings fields
// ----------------------------------------
`define HBAC_BS_CAP_BIT 7
`define HBAC_BS_NEAR_FULL_BIT 6
`define HBAC_BS_NEAR_EMPTY_BIT 5
`define HBAC_BS_CLEAR_BIT 4
`define HBAC_BS_THR_MSB_BIT 2
`define HBAC_BS_FILL_MSB 1
`define HBAC_BS_FILL_LSB 0
`define HBAC_BS_RESET 8'h00
`define HBAC_CAP_SMALL 10'h0ff
`define HBAC_CAP_LARGE 10'h200

`endif

// ---- hbac_engine_model.sv ----
module hbac_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the register bank
  input wire logic command_start,
  input wire logic power_down,
  input wire logic buffer_clear,
  // Fill level requested by the bench
  input wire logic load,
  input wire logic [9:0] fill_req,
  // To the register bank
  output logic command_done,
  output logic wakeup,
  output logic [9:0] buffer_fill_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;

  // Random finish delay so that both prompt and slow commands occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      command_done <= 1'b0;
      wakeup <= 1'b0;
      buffer_fill_count <= 10'h000;
    end else begin
      command_done <= cnt_r == 4'h1;
      cnt_r <= command_start ? 4'(2 + $urandom % 8) : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
      wakeup <= power_down && !wakeup;
      buffer_fill_count <= buffer_clear ? 10'h000 : (load ? fill_req : buffer_fill_count);
    end
  end
endmodule

// ---- hbac_host_ctrl.sv ----
`include "hbac_defines.svh"

module hbac_host_ctrl
  import hbac_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Writes
  input hbac_wr_t host_wr,
  input wire logic any_wr,
  // State
  output hbac_host_state_t state
);

  hbac_host_state_t state_r;
  hbac_host_state_t state_nxt;
  logic want_host;
  logic want_sm;
  logic take_owner;

  assign want_host = host_wr.data[`HBAC_HB_OWN_HOST_BIT];
  assign want_sm = host_wr.data[`HBAC_HB_OWN_SM_BIT];
  // Both at once is refused but still spends the unlock
  assign take_owner = state_r.unlock && !(want_host && want_sm);

  always_comb begin
    state_nxt = state_r;
    if (host_wr.en) begin
      state_nxt.sm_if = hbac_sm_if_t'(host_wr.data[`HBAC_HB_IF_MSB:`HBAC_HB_IF_LSB]);
      if (take_owner) begin
        state_nxt.own_host = want_host;
        state_nxt.own_sm = want_sm;
      end else begin
        // Clearing ownership needs no unlock
        state_nxt.own_host = state_r.own_host & want_host;
        state_nxt.own_sm = state_r.own_sm & want_sm;
      end
    end
    if (any_wr) begin
      if (state_r.unlock) begin
        state_nxt.unlock = 1'b0;
      end else if (host_wr.en) begin
        state_nxt.unlock = host_wr.data[`HBAC_HB_UNLOCK_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;

endmodule

// ---- hbac_level.sv ----
`include "hbac_defines.svh"

module hbac_level
  import hbac_pkg::*;
(
  input hbac_level_in_t lvl,
  output logic near_full,
  output logic near_empty
);

  logic [9:0] cap;
  logic [9:0] fill;
  logic [9:0] thr;
  logic [9:0] room;

  // In the small mode only the low byte of count and threshold counts
  assign cap = lvl.small_mode ? `HBAC_CAP_SMALL : `HBAC_CAP_LARGE;
  assign fill = lvl.small_mode ? {2'b00, lvl.fill[7:0]} : lvl.fill;
  assign thr = lvl.small_mode ? {2'b00, lvl.threshold[7:0]} : {1'b0, lvl.threshold};
  assign room = (fill > cap) ? 10'h000 : cap - fill;
  assign near_full = room <= thr;
  assign near_empty = fill <= thr;

endmodule

// ---- hbac_pkg.sv ----
package hbac_pkg;

  // Secure module interface selection
  typedef enum logic [1:0] {
    HBAC_SM_OFF = 2'b00,
    HBAC_SM_SPI = 2'b01,
    HBAC_SM_LOW_SPEED_TWO_WIRE = 2'b10,
    HBAC_SM_TWO_WIRE = 2'b11
  } hbac_sm_if_t;

  // One register write as seen by a field owner
  typedef struct packed {
    logic en;
    logic [7:0] data;
  } hbac_wr_t;

  // Bus ownership and interface selection
  typedef struct packed {
    logic unlock;
    logic own_host;
    logic own_sm;
    hbac_sm_if_t sm_if;
  } hbac_host_state_t;

  // Buffer fill view used by the level flags
  typedef struct packed {
    logic [9:0] fill;
    logic [8:0] threshold;
    logic small_mode;
  } hbac_level_in_t;

endpackage

// ---- hbac_top.sv ----
// Operation
// - Writing 1 to bit 7 of command_control puts the device into power-down.
// - Bit 6 of command_control powers the receiver and transmitter down while set.
// - Bits 4 to 0 of command_control hold the code of the running command, written to launch it.
// - The device returns the command code to idle by itself when the command finishes.
// - Setting the unlock bit 7 of host_bus_access lets the next write modify that register.
// - The first write after the unlock bit is set clears it, so one unlock allows one change.
// - Bit 6 of host_bus_access hands the bus to the host.
// - Bit 5 of host_bus_access hands the bus to the secure module.
// - The two ownership bits are never set together.
// - An ownership bit can only be set when the unlock was set by an earlier access.
// - Bits 3 to 2 of host_bus_access select off, SPI, low-speed two-wire or two-wire.
// - A read-only register at index 7Fh reports version and subversion.
// - Bit 7 of buffer_settings selects 255 bytes when 1 and 512 bytes when 0.
// - Writing 1 to bit 4 of buffer_settings empties the buffer and the bit reads 0.

`include "hbac_defines.svh"

module hbac_top
  import hbac_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [3:0] VERSION = 4'h1,   // Arbitrary value
  parameter logic [3:0] SUBVERSION = 4'h0 // Arbitrary value
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command engine
  input wire logic command_done,
  input wire logic wakeup,
  output logic power_down,
  output logic radio_power_off,
  output logic [4:0] command_code,
  output logic command_start,
  // Bus access
  output logic bus_owner_host,
  output logic bus_owner_secure_module,
  output hbac_sm_if_t secure_module_if_select,
  // Buffer
  input wire logic [9:0] buffer_fill_count,
  input wire logic [7:0] threshold_low,
  output logic buffer_capacity_select,
  output logic threshold_msb,
  output logic buffer_clear
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W < `HBAC_IDX_W + 2) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [`HBAC_IDX_W-1:0] idx);
    logic [ADDR_W-1:0] byte_addr;
    byte_addr = '0;
    byte_addr[`HBAC_IDX_W+1:0] = {idx, 2'b00};
    idx_hit = (a == byte_addr);
  endfunction

  logic hit_cmd;
  logic hit_host;
  logic hit_buf;
  logic hit_ver;
  logic hit_any;
  logic setup;
  logic access;
  logic wr_ok;
  logic rd_setup;

  assign hit_cmd = idx_hit(paddr, `HBAC_IDX_COMMAND);
  assign hit_host = idx_hit(paddr, `HBAC_IDX_HOST_BUS);
  assign hit_buf = idx_hit(paddr, `HBAC_IDX_BUF_SET);
  assign hit_ver = idx_hit(paddr, `HBAC_IDX_VERSION);
  assign hit_any = hit_cmd | hit_host | hit_buf | hit_ver;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  // Only the low byte lane carries register data
  assign wr_ok = access & pwrite & hit_any & pstrb[0];
  assign rd_setup = setup & ~pwrite;

  // Zero wait states; read data is captured at the setup edge
  assign pready = 1'b1;
  assign pslverr = access & (~hit_any | (pwrite & hit_ver));

  logic wr_cmd;
  logic wr_host;
  logic wr_buf;

  assign wr_cmd = wr_ok & hit_cmd;
  assign wr_host = wr_ok & hit_host;
  assign wr_buf = wr_ok & hit_buf;

  // ----------------------------------------
  // command_control
  // ----------------------------------------
  logic pwrdn_r;
  logic pwrdn_nxt;
  logic radio_off_r;
  logic radio_off_nxt;
  logic [4:0] code_r;
  logic [4:0] code_nxt;
  logic start_r;
  logic start_nxt;
  logic [4:0] wr_code;

  assign wr_code = pwdata[`HBAC_CMD_CODE_MSB:`HBAC_CMD_CODE_LSB];

  always_comb begin
    pwrdn_nxt = pwrdn_r;
    radio_off_nxt = radio_off_r;
    code_nxt = code_r;
    start_nxt = 1'b0;
    // Completion first, so a launch in the same cycle is not lost
    if (command_done) begin
      code_nxt = `HBAC_CMD_CODE_IDLE;
    end
    if (wakeup) begin
      pwrdn_nxt = 1'b0;
    end
    if (wr_cmd) begin
      pwrdn_nxt = pwdata[`HBAC_CMD_PWRDN_BIT] | pwrdn_r;
      radio_off_nxt = pwdata[`HBAC_CMD_RADIO_OFF_BIT];
      code_nxt = wr_code;
      start_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrdn_r <= 1'b0;
      radio_off_r <= 1'b0;
      code_r <= `HBAC_CMD_CODE_IDLE;
      start_r <= 1'b0;
    end else begin
      pwrdn_r <= pwrdn_nxt;
      radio_off_r <= radio_off_nxt;
      code_r <= code_nxt;
      start_r <= start_nxt;
    end
  end

  assign power_down = pwrdn_r;
  assign radio_power_off = radio_off_r;
  assign command_code = code_r;
  assign command_start = start_r;

  // ----------------------------------------
  // host_bus_access
  // ----------------------------------------
  hbac_wr_t host_wr;
  hbac_host_state_t host_st;

  assign host_wr.en = wr_host;
  assign host_wr.data = pwdata[7:0];

  hbac_host_ctrl u_host_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .host_wr(host_wr),
    .any_wr(wr_ok),
    .state(host_st)
  );

  assign bus_owner_host = host_st.own_host;
  assign bus_owner_secure_module = host_st.own_sm;
  assign secure_module_if_select = host_st.sm_if;

  // ----------------------------------------
  // buffer_settings
  // ----------------------------------------
  logic cap_sel_r;
  logic thr_msb_r;
  logic clear_r;
  logic near_full;
  logic near_empty;
  hbac_level_in_t lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sel_r <= 1'b0;
      thr_msb_r <= 1'b0;
      clear_r <= 1'b0;
    end else begin
      if (wr_buf) begin
        cap_sel_r <= pwdata[`HBAC_BS_CAP_BIT];
        thr_msb_r <= pwdata[`HBAC_BS_THR_MSB_BIT];
      end
      clear_r <= wr_buf & pwdata[`HBAC_BS_CLEAR_BIT];
    end
  end

  assign lvl.fill = buffer_fill_count;
  assign lvl.threshold = {thr_msb_r, threshold_low};
  assign lvl.small_mode = cap_sel_r;

  hbac_level u_level (
    .lvl(lvl),
    .near_full(near_full),
    .near_empty(near_empty)
  );

  assign buffer_capacity_select = cap_sel_r;
  assign threshold_msb = thr_msb_r;
  assign buffer_clear = clear_r;

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  logic [7:0] rd_cmd;
  logic [7:0] rd_host;
  logic [7:0] rd_buf;
  logic [7:0] rd_ver;
  logic [7:0] rd_sel;
  logic [31:0] prdata_r;

  // Reserved bits read as zero
  assign rd_cmd = {pwrdn_r, radio_off_r, 1'b0, code_r};
  assign rd_host = {host_st.unlock, host_st.own_host, host_st.own_sm, 1'b0, host_st.sm_if, 2'b00};
  // Clear bit always reads 0; count msbs only mean something in the large mode
  assign rd_buf = {cap_sel_r, near_full, near_empty, 1'b0, 1'b0, thr_msb_r,
                   cap_sel_r ? 2'b00 : buffer_fill_count[9:8]};
  assign rd_ver = {VERSION, SUBVERSION};
  assign rd_sel = ({8{hit_cmd}} & rd_cmd) | ({8{hit_host}} & rd_host) |
                  ({8{hit_buf}} & rd_buf) | ({8{hit_ver}} & rd_ver);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= {24'h00_0000, rd_sel};
    end
  end

  assign prdata = prdata_r;

endmodule

// ---- hbac_top_checker.sv ----
`include "hbac_defines.svh"

module hbac_top_checker
  import hbac_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  // Command and bus access
  input wire logic command_done,
  input wire logic power_down,
  input wire logic radio_power_off,
  input wire logic [4:0] command_code,
  input wire logic command_start,
  input wire logic bus_owner_host,
  input wire logic bus_owner_secure_module,
  input hbac_sm_if_t secure_module_if_select,
  // Buffer
  input wire logic buffer_capacity_select,
  input wire logic buffer_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [ADDR_W-1:0] A0 = ADDR_W'({`HBAC_IDX_COMMAND, 2'b00});
  localparam logic [ADDR_W-1:0] A1 = ADDR_W'({`HBAC_IDX_HOST_BUS, 2'b00});
  localparam logic [ADDR_W-1:0] A2 = ADDR_W'({`HBAC_IDX_BUF_SET, 2'b00});
  localparam logic [ADDR_W-1:0] AV = ADDR_W'({`HBAC_IDX_VERSION, 2'b00});
  wire wr = psel && penable && pwrite && pstrb[0];
  wire w0 = wr && paddr == A0;
  wire w1 = wr && paddr == A1;
  wire w2 = wr && paddr == A2;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pd_set_a: assert property (w0 && pwdata[7] |=> power_down) else $error("power-down not entered");
  radio_off_a: assert property (w0 |=> radio_power_off == $past(pwdata[6]))
    else $error("radio power bit wrong");
  code_load_a: assert property (w0 |=> command_code == $past(pwdata[4:0]) && command_start)
    else $error("command code not launched");
  code_done_a: assert property (command_done && !w0 |=> command_code == 5'h00)
    else $error("command code not returned to idle");
  owner_excl_a: assert property (!(bus_owner_host && bus_owner_secure_module)) else $error("two bus owners");
  owner_cause_a: assert property ($rose(bus_owner_host) || $rose(bus_owner_secure_module) |-> $past(w1))
    else $error("owner set without a write");
  if_select_a: assert property (w1 |=> secure_module_if_select == $past(pwdata[3:2]))
    else $error("interface select wrong");
  version_err_a: assert property (psel && penable && paddr == AV |-> pslverr == pwrite)
    else $error("version access response wrong");
  cap_sel_a: assert property (w2 |=> buffer_capacity_select == $past(pwdata[7]))
    else $error("capacity select wrong");
  clear_pulse_a: assert property (w2 && pwdata[4] |=> buffer_clear ##1 !buffer_clear)
    else $error("buffer clear pulse wrong");
endmodule

bind hbac_top hbac_top_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pslverr, .command_done, .power_down, .radio_power_off, .command_code, .command_start,
  .bus_owner_host, .bus_owner_secure_module, .secure_module_if_select, .buffer_capacity_select, .buffer_clear);

// ---- host_command_and_bus_access_ctrl_tb.sv ----
`include "hbac_defines.svh"

module host_command_and_bus_access_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hbac_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 0, err, unl = 0, c, m;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] pprot = 3'h0;
  logic [9:0] fill_req = 10'h000, f, buffer_fill_count;
  logic [7:0] thr = 8'h00, v, t;
  logic [1:0] own = 2'b00, ifs = 2'b00;
  logic pready, pslverr, command_done, wakeup, power_down, radio_power_off, command_start;
  logic bus_owner_host, bus_owner_secure_module, buffer_capacity_select, threshold_msb, buffer_clear;
  logic [4:0] command_code;
  hbac_sm_if_t secure_module_if_select;
  logic [8:0] tab [14] = '{9'h040, 9'h080, 9'h060, 9'h080, 9'h044, 9'h080, 9'h028, 9'h0c8, 9'h02c,
    9'h080, 9'h100, 9'h040, 9'h080, 9'h000};
  int miscompares = 0, n_tests = 0, n;

  // Version values are arbitrary
  hbac_top #(.VERSION(4'h3), .SUBVERSION(4'h5)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .command_done, .wakeup, .power_down, .radio_power_off,
    .command_code, .command_start, .bus_owner_host, .bus_owner_secure_module, .secure_module_if_select,
    .buffer_fill_count, .threshold_low(thr), .buffer_capacity_select, .threshold_msb, .buffer_clear);
  hbac_engine_model i_eng (.pclk, .presetn, .command_start, .power_down, .buffer_clear, .load, .fill_req,
    .command_done, .wakeup, .buffer_fill_count);

  initial forever #12.5 pclk = ~pclk;

  task finish_test();
    $display("Mismatches %0d of %0d comparisons", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task apb(input logic w, input logic [6:0] idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, idx, 2'b00};
    pwdata <= {24'($urandom), d};
    pstrb <= s;
    pprot <= 3'($urandom);
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(pready, 1'b1, "access answered");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write through the bus and track the unlock and ownership state
  task wr(input logic [6:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'h1);
    if (unl) begin
      if (idx == `HBAC_IDX_HOST_BUS && d[6:5] != 2'b11) own = d[6:5];
      if (idx == `HBAC_IDX_HOST_BUS) ifs = d[3:2];
      unl = 1'b0;
    end else if (idx == `HBAC_IDX_HOST_BUS) begin
      unl = d[7];
      own = own & d[6:5];
      ifs = d[3:2];
    end
  endtask

  task hchk();
    apb(1'b0, `HBAC_IDX_HOST_BUS, 8'h00, 4'h0);
    chk(rd, {24'h0, unl, own, 1'b0, ifs, 2'b00}, "host access read");
    chk({bus_owner_host, bus_owner_secure_module, secure_module_if_select}, {own, ifs}, "owners");
  endtask

  function logic [7:0] exp_buf(logic cp, logic ms, logic [9:0] fl, logic [7:0] th);
    int cap, lim, lv;
    cap = cp ? 255 : 512;
    lim = cp ? th : {ms, th};
    lv = cp ? fl[7:0] : fl;
    return {cp, cap - lv <= lim, lv <= lim, 2'b00, ms, cp ? 2'b00 : fl[9:8]};
  endfunction

  initial begin
    void'($urandom(44977));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `HBAC_IDX_COMMAND, 8'h00, 4'h0);
    chk(rd, 32'h0, "command reset");
    hchk();
    apb(1'b0, `HBAC_IDX_BUF_SET, 8'h00, 4'h0);
    chk(rd, exp_buf(0, 0, 10'h000, 8'h00), "buffer reset");
    wr(`HBAC_IDX_VERSION, 8'hff);
    chk(err, 1'b1, "version write error");
    apb(1'b0, `HBAC_IDX_VERSION, 8'h00, 4'h0);
    chk(rd, {24'h00_0000, 4'h3, 4'h5}, "version read");
    chk(err, 1'b0, "version read error");
    apb(1'b0, 7'h10, 8'h00, 4'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    apb(1'b1, `HBAC_IDX_HOST_BUS, 8'h80, 4'h0);
    hchk();
    // Corner sequences first, then random host traffic
    for (int i = 0; i < 26; i++) begin
      v = i < 14 ? tab[i][7:0] : 8'($urandom);
      wr((i < 14 ? tab[i][8] : 1'($urandom)) ? `HBAC_IDX_BUF_SET : `HBAC_IDX_HOST_BUS, v);
      hchk();
    end
    for (int i = 0; i < 8; i++) begin
      v = i == 0 ? 8'h9f : (i == 1 ? 8'h40 : 8'($urandom));
      wr(`HBAC_IDX_COMMAND, v);
      @(negedge pclk);
      chk({power_down | ~v[7], radio_power_off, command_code, command_start}, {1'b1, v[6], v[4:0], 1'b1}, "cmd");
      for (n = 0; n < 40 && command_done !== 1'b1; n++) @(posedge pclk);
      apb(1'b0, `HBAC_IDX_COMMAND, 8'h00, 4'h0);
      chk(rd[6:0], {v[6], 6'h00}, "command idle");
      chk(power_down, 1'b0, "wakeup");
    end
    load <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      c = 1'($urandom);
      m = 1'($urandom);
      t = 8'($urandom);
      f = i == 0 ? {2'b00, t} : (i == 1 ? (c ? 10'h0ff - t : 10'h200 - {m, t}) : 10'($urandom % (c ? 256 : 513)));
      thr <= t;
      fill_req <= f;
      // Reserved bit 3 is written back as it reads, zero
      wr(`HBAC_IDX_BUF_SET, {c, 4'h0, m, 2'b00});
      apb(1'b0, `HBAC_IDX_BUF_SET, 8'h00, 4'h0);
      chk(rd[7:0], exp_buf(c, m, f, t), "buffer flags");
      chk(buffer_capacity_select, c, "capacity select");
      chk(threshold_msb, m, "threshold msb");
    end
    load <= 1'b0;
    wr(`HBAC_IDX_BUF_SET, 8'h10);
    @(negedge pclk);
    chk(buffer_clear, 1'b1, "clear pulse");
    @(negedge pclk);
    chk(buffer_clear, 1'b0, "clear end");
    apb(1'b0, `HBAC_IDX_BUF_SET, 8'h00, 4'h0);
    chk(rd[7:0], exp_buf(0, 0, 10'h000, t), "cleared");
    finish_test();
  end

  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
endmodule
